// file: hw/csrp_pkg.sv
package csrp_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_LST, OP_STATUS1_LOAD_INSTR, OP_AUX_POINTER_LOAD_INSTR, OP_MAR, OP_LDP, OP_PAGE_LOAD_IMM_INSTR,
    OP_SC, OP_RC, OP_BLOCK_TO_DATA_INSTR, OP_BLOCK_TO_PROG_INSTR, OP_CFG_MODE_LOAD_INSTR, OP_SERIAL_WIDTH_INSTR, OP_INT_DISABLE_INSTR,
    OP_INT_ENABLE_INSTR, OP_SATURATE_ON_INSTR, OP_SATURATE_OFF_INSTR, OP_SPM, OP_SSXM, OP_RSXM, OP_STXM,
    OP_RTXM, OP_SXF, OP_RXF, OP_BC, OP_BNC, OP_BV, OP_BNV,
    OP_BTC, OP_BNTC, OP_TXWR
  } csrp_op_e;

  localparam int W0_ARP_LO = 13;
  localparam int W0_OV = 12;
  localparam int W0_OVM = 11;
  localparam int W0_RSV = 10;
  localparam int W0_GLOBAL_INT_MASK = 9;
  localparam int W0_DP_LO = 0;
  localparam int W1_ARB_LO = 13;
  localparam int W1_CNF = 12;
  localparam int W1_TC = 11;
  localparam int W1_SXM = 10;
  localparam int W1_C = 9;
  localparam int W1_RSV = 8;
  localparam int W1_RAM_CFG_BIT_HIGH = 7;
  localparam int W1_HM = 6;
  localparam int W1_FSM = 5;
  localparam int W1_XF = 4;
  localparam int W1_FO = 3;
  localparam int W1_TXM = 2;
  localparam int W1_PM_LO = 0;
  localparam int DIR_OFS_W = 7;

  localparam logic RST_OV = 1'b0;
  localparam logic RST_XF = 1'b1;
  localparam logic RST_FO = 1'b0;
  localparam logic RST_TXM = 1'b0;
  localparam logic RST_CNF = 1'b0;
  localparam logic RST_SXM = 1'b1;
  localparam logic RST_HM = 1'b1;
  localparam logic RST_C = 1'b1;
  localparam logic RST_FSM = 1'b1;
  localparam logic RST_GLOBAL_INT_MASK = 1'b1;
  localparam logic [1:0] RST_PM = 2'h0;
  localparam logic [2:0] RST_PTR = 3'h0;
  localparam logic [8:0] RST_DP = 9'h000;
  localparam logic RST_OVM = 1'b0;
  localparam logic RST_TC = 1'b0;

  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_LEFT1 = 2'h1;
  localparam logic [1:0] PM_LEFT4 = 2'h2;
  localparam logic [1:0] PM_RIGHT6 = 2'h3;
endpackage

// file: hw/csrp_status_pair.sv
`timescale 1ns/1ps
module csrp_status_pair #(
  parameter bit FOUR_MODE = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic op_valid_in,
  input wire csrp_pkg::csrp_op_e op_code_in,
  input wire logic [15:0] op_data_in,
  input wire logic ind_arp_we_in,
  input wire logic [2:0] ind_arp_in,
  input wire logic alu_add_in,
  input wire logic alu_sub_in,
  input wire logic alu_high_in,
  input wire logic alu_carry_in,
  input wire logic shift_c_we_in,
  input wire logic shift_c_in,
  input wire logic alu_ovf_in,
  input wire logic tc_we_in,
  input wire logic tc_in,
  input wire logic int_ack_in,
  input wire logic unsigned_op_in,
  input wire logic [6:0] dir_offset_in,
  input wire logic [31:0] product_in,
  output logic [15:0] status_word_zero_out,
  output logic [15:0] status_word_one_out,
  output logic [15:0] direct_addr_out,
  output logic [31:0] product_alu_out,
  output logic sign_ext_en_out,
  output logic branch_take_out,
  output logic general_output_pin_out,
  output logic tx_frame_sync_pin_out,
  output logic tx_frame_sync_pin_oe_out,
  output logic [1:0] ram_cfg_out
);
  import csrp_pkg::*;

  logic [2:0] arp_q, arp_d, arb_q, arb_d;
  logic [8:0] dp_q, dp_d;
  logic ov_q, ov_d, ovm_q, ovm_d, global_int_mask_q, global_int_mask_d;
  logic cnf_q, cnf_d, ram_cfg_bit_high_q, ram_cfg_bit_high_d, tc_q, tc_d;
  logic sxm_q, sxm_d, c_q, c_d, hm_q, hm_d, fsm_q, fsm_d;
  logic xf_q, xf_d, fo_q, fo_d, txm_q, txm_d;
  logic [1:0] pm_q, pm_d;
  logic br_q, br_d, fsx_q, fsx_d;
  logic [15:0] addr_q;
  logic [31:0] prod_q, prod_d;
  logic ext_q;
  logic [15:0] w0_q, w0_d, w1_q, w1_d;

  // Word images of the reset state; a change to a bit's reset value carries over
  localparam logic [15:0] RST_W0 = {RST_PTR, RST_OV, RST_OVM, 1'b1, RST_GLOBAL_INT_MASK, RST_DP};
  localparam logic [15:0] RST_W1 = {RST_PTR, RST_CNF, RST_TC, RST_SXM, RST_C, 1'b1,
    FOUR_MODE ? RST_CNF : 1'b1, RST_HM, RST_FSM, RST_XF, RST_FO, RST_TXM, RST_PM};

  // Page and offset must fill the direct address exactly
  if (DIR_OFS_W + 9 != 16) begin : g_addr_fit
    $error("direct address split does not fill sixteen bits");
  end

  wire op_lst = op_valid_in && op_code_in == OP_LST;
  wire op_status1_load_instr = op_valid_in && op_code_in == OP_STATUS1_LOAD_INSTR;
  wire [15:0] w0_in = op_data_in;
  wire [15:0] w1_in = op_data_in;
  // Pointer load by the two pointer-load instructions only; indirect update and word-one restore load it apart
  wire op_ptr = op_valid_in && (op_code_in == OP_AUX_POINTER_LOAD_INSTR || op_code_in == OP_MAR);
  wire arp_push = op_ptr || ind_arp_we_in;
  wire [2:0] arp_new = op_ptr ? op_data_in[2:0] : ind_arp_in;

  function automatic logic is_op(input csrp_op_e code);
    is_op = op_valid_in && op_code_in == code;
  endfunction

  always_comb begin
    arp_d = arp_q;
    arb_d = arb_q;
    dp_d = dp_q;
    ov_d = ov_q;
    ovm_d = ovm_q;
    global_int_mask_d = global_int_mask_q;
    cnf_d = cnf_q;
    ram_cfg_bit_high_d = ram_cfg_bit_high_q;
    tc_d = tc_q;
    sxm_d = sxm_q;
    c_d = c_q;
    hm_d = hm_q;
    fsm_d = fsm_q;
    xf_d = xf_q;
    fo_d = fo_q;
    txm_d = txm_q;
    pm_d = pm_q;
    if (arp_push) begin
      arb_d = arp_q;
      arp_d = arp_new;
    end
    if (op_lst) begin
      // Mask bit deliberately skipped here
      arp_d = w0_in[W0_ARP_LO +: 3];
      ov_d = w0_in[W0_OV];
      ovm_d = w0_in[W0_OVM];
      dp_d = w0_in[W0_DP_LO +: 9];
    end
    if (op_status1_load_instr) begin
      arb_d = w1_in[W1_ARB_LO +: 3];
      arp_d = w1_in[W1_ARB_LO +: 3];
      cnf_d = w1_in[W1_CNF];
      tc_d = w1_in[W1_TC];
      sxm_d = w1_in[W1_SXM];
      c_d = w1_in[W1_C];
      if (FOUR_MODE) begin
        ram_cfg_bit_high_d = w1_in[W1_RAM_CFG_BIT_HIGH];
      end
      hm_d = w1_in[W1_HM];
      fsm_d = w1_in[W1_FSM];
      xf_d = w1_in[W1_XF];
      fo_d = w1_in[W1_FO];
      txm_d = w1_in[W1_TXM];
      pm_d = w1_in[W1_PM_LO +: 2];
    end
    if (is_op(OP_LDP) || is_op(OP_PAGE_LOAD_IMM_INSTR)) begin
      dp_d = op_data_in[8:0];
    end
    if (is_op(OP_SC)) begin
      c_d = 1'b1;
    end
    if (is_op(OP_RC)) begin
      c_d = 1'b0;
    end
    if (shift_c_we_in) begin
      c_d = shift_c_in;
    end
    // Carry input is carry-out on add and not-borrow on subtract
    if (alu_add_in) begin
      c_d = alu_high_in ? (c_q | alu_carry_in) : alu_carry_in;
    end
    if (alu_sub_in) begin
      c_d = alu_high_in ? (c_q & alu_carry_in) : alu_carry_in;
    end
    if (is_op(OP_BLOCK_TO_DATA_INSTR)) begin
      cnf_d = 1'b0;
    end
    if (is_op(OP_BLOCK_TO_PROG_INSTR)) begin
      cnf_d = 1'b1;
    end
    if (FOUR_MODE && is_op(OP_CFG_MODE_LOAD_INSTR)) begin
      cnf_d = op_data_in[0];
      ram_cfg_bit_high_d = op_data_in[1];
    end
    if (is_op(OP_SERIAL_WIDTH_INSTR)) begin
      fo_d = op_data_in[0];
    end
    if (is_op(OP_INT_ENABLE_INSTR)) begin
      global_int_mask_d = 1'b0;
    end
    if (is_op(OP_INT_DISABLE_INSTR) || int_ack_in) begin
      global_int_mask_d = 1'b1;
    end
    if (is_op(OP_SATURATE_ON_INSTR)) begin
      ovm_d = 1'b1;
    end
    if (is_op(OP_SATURATE_OFF_INSTR)) begin
      ovm_d = 1'b0;
    end
    if (is_op(OP_SPM)) begin
      pm_d = op_data_in[1:0];
    end
    if (is_op(OP_SSXM)) begin
      sxm_d = 1'b1;
    end
    if (is_op(OP_RSXM)) begin
      sxm_d = 1'b0;
    end
    if (is_op(OP_STXM)) begin
      txm_d = 1'b1;
    end
    if (is_op(OP_RTXM)) begin
      txm_d = 1'b0;
    end
    if (is_op(OP_SXF)) begin
      xf_d = 1'b1;
    end
    if (is_op(OP_RXF)) begin
      xf_d = 1'b0;
    end
    if (tc_we_in) begin
      tc_d = tc_in;
    end
    if (is_op(OP_BV) || is_op(OP_BNV)) begin
      ov_d = 1'b0;
    end
    // A fresh overflow beats any clear in the same cycle
    if (alu_ovf_in) begin
      ov_d = 1'b1;
    end
  end

  // Branch decision uses the flags before this cycle's update
  always_comb begin
    case (op_code_in)
      OP_BC: br_d = op_valid_in && c_q;
      OP_BNC: br_d = op_valid_in && !c_q;
      OP_BV: br_d = op_valid_in && ov_q;
      OP_BNV: br_d = op_valid_in && !ov_q;
      OP_BTC: br_d = op_valid_in && tc_q;
      OP_BNTC: br_d = op_valid_in && !tc_q;
      default: br_d = 1'b0;
    endcase
  end

  assign fsx_d = is_op(OP_TXWR) && txm_q;

  always_comb begin
    case (pm_q)
      PM_LEFT1: prod_d = {product_in[30:0], 1'b0};
      PM_LEFT4: prod_d = {product_in[27:0], 4'h0};
      PM_RIGHT6: prod_d = {{6{product_in[31]}}, product_in[31:6]};
      default: prod_d = product_in;
    endcase
  end

  // Bits with no documented reset value still start at zero here
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      arp_q <= RST_PTR;
      arb_q <= RST_PTR;
      dp_q <= RST_DP;
    end else begin
      arp_q <= arp_d;
      arb_q <= arb_d;
      dp_q <= dp_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ovm_q <= RST_OVM;
      tc_q <= RST_TC;
      ov_q <= RST_OV;
      global_int_mask_q <= RST_GLOBAL_INT_MASK;
    end else begin
      ovm_q <= ovm_d;
      tc_q <= tc_d;
      ov_q <= ov_d;
      global_int_mask_q <= global_int_mask_d;
    end
  end

  // Carry and sign extension leave reset set, with all RAM blocks in data space
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cnf_q <= RST_CNF;
      ram_cfg_bit_high_q <= RST_CNF;
      sxm_q <= RST_SXM;
      c_q <= RST_C;
    end else begin
      cnf_q <= cnf_d;
      ram_cfg_bit_high_q <= ram_cfg_bit_high_d;
      sxm_q <= sxm_d;
      c_q <= c_d;
    end
  end

  // Serial, hold and flag modes: framed, halting, flag pin high, transmit frame pin an input
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      hm_q <= RST_HM;
      fsm_q <= RST_FSM;
      xf_q <= RST_XF;
      fo_q <= RST_FO;
      txm_q <= RST_TXM;
      pm_q <= RST_PM;
    end else begin
      hm_q <= hm_d;
      fsm_q <= fsm_d;
      xf_q <= xf_d;
      fo_q <= fo_d;
      txm_q <= txm_d;
      pm_q <= pm_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      br_q <= 1'b0;
      fsx_q <= 1'b0;
      addr_q <= 16'h0000;
      prod_q <= 32'h0000_0000;
      ext_q <= 1'b0;
    end else begin
      br_q <= br_d;
      fsx_q <= fsx_d;
      addr_q <= {dp_q, dir_offset_in};
      prod_q <= prod_d;
      ext_q <= sxm_q && !unsigned_op_in;
    end
  end

  // Reserved positions are constant ones, so a store always shows them set
  // Built from next-state bits so the registered words never lag the flags they show
  always_comb begin
    w0_d = 16'h0000;
    w0_d[W0_ARP_LO +: 3] = arp_d;
    w0_d[W0_OV] = ov_d;
    w0_d[W0_OVM] = ovm_d;
    w0_d[W0_RSV] = 1'b1;
    w0_d[W0_GLOBAL_INT_MASK] = global_int_mask_d;
    w0_d[W0_DP_LO +: 9] = dp_d;
    w1_d = 16'h0000;
    w1_d[W1_ARB_LO +: 3] = arb_d;
    w1_d[W1_CNF] = cnf_d;
    w1_d[W1_TC] = tc_d;
    w1_d[W1_SXM] = sxm_d;
    w1_d[W1_C] = c_d;
    w1_d[W1_RSV] = 1'b1;
    w1_d[W1_RAM_CFG_BIT_HIGH] = FOUR_MODE ? ram_cfg_bit_high_d : 1'b1;
    w1_d[W1_HM] = hm_d;
    w1_d[W1_FSM] = fsm_d;
    w1_d[W1_XF] = xf_d;
    w1_d[W1_FO] = fo_d;
    w1_d[W1_TXM] = txm_d;
    w1_d[W1_PM_LO +: 2] = pm_d;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      w0_q <= RST_W0;
      w1_q <= RST_W1;
    end else begin
      w0_q <= w0_d;
      w1_q <= w1_d;
    end
  end

  // Every output is a flop; the words have their own register pair
  assign status_word_zero_out = w0_q;
  assign status_word_one_out = w1_q;
  assign direct_addr_out = addr_q;
  assign product_alu_out = prod_q;
  assign sign_ext_en_out = ext_q;
  assign branch_take_out = br_q;
  assign general_output_pin_out = xf_q;
  assign tx_frame_sync_pin_out = fsx_q;
  assign tx_frame_sync_pin_oe_out = txm_q;
  assign ram_cfg_out = {ram_cfg_bit_high_q, cnf_q};
endmodule

// file: tb/csrp_status_pair_sva.sv
`timescale 1ns/1ps
module csrp_status_pair_chk
  import csrp_pkg::*;
#(
  parameter bit FOUR_MODE = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic op_valid_in,
  input wire csrp_pkg::csrp_op_e op_code_in,
  input wire logic [15:0] op_data_in,
  input wire logic unsigned_op_in,
  input wire logic [6:0] dir_offset_in,
  input wire logic [31:0] product_in,
  input wire logic [15:0] status_word_zero_out,
  input wire logic [15:0] status_word_one_out,
  input wire logic [15:0] direct_addr_out,
  input wire logic [31:0] product_alu_out,
  input wire logic sign_ext_en_out,
  input wire logic branch_take_out,
  input wire logic tx_frame_sync_pin_out,
  input wire logic tx_frame_sync_pin_oe_out
);
  localparam logic [15:0] RST1 = FOUR_MODE ? 16'h0770 : 16'h07f0;
  wire [15:0] w0 = status_word_zero_out;
  wire [15:0] w1 = status_word_one_out;
  wire op_ok = op_valid_in;

  function automatic logic [31:0] shp(input logic [31:0] p, input logic [1:0] m);
    case (m)
      PM_LEFT1: shp = p << 1;
      PM_LEFT4: shp = p << 4;
      PM_RIGHT6: shp = {{6{p[31]}}, p[31:6]};
      default: shp = p;
    endcase
  endfunction

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_reset_words: assert property (disable iff (1'b0) !rst_n_in |=> w0 == 16'h0600 && w1 == RST1)
    else $error("status words wrong after reset");
  a_mask_not_restored: assert property (op_ok && op_code_in == OP_LST |=> w0[9] == $past(w0[9]))
    else $error("word zero restore changed the mask");
  a_pointer_push: assert property (op_ok && op_code_in inside {OP_AUX_POINTER_LOAD_INSTR, OP_MAR}
    |=> w1[15:13] == $past(w0[15:13]) && w0[15:13] == $past(op_data_in[2:0]))
    else $error("pointer load did not push old value");
  a_branch_carry: assert property (op_ok && op_code_in == OP_BC |=> branch_take_out == $past(w1[9]))
    else $error("carry branch wrong");
  a_product_path: assert property ($past(rst_n_in) |-> product_alu_out == shp($past(product_in), $past(w1[1:0])))
    else $error("product shift wrong");
  a_direct_addr: assert property ($past(rst_n_in) |-> direct_addr_out == {$past(w0[8:0]), $past(dir_offset_in)})
    else $error("direct address wrong");
  a_tx_frame_pulse: assert property ($past(rst_n_in) |-> tx_frame_sync_pin_oe_out == w1[2] &&
    tx_frame_sync_pin_out == $past(op_ok && op_code_in == OP_TXWR && w1[2]))
    else $error("transmit frame pulse wrong");
  a_sign_ext_gate: assert property ($past(rst_n_in) |-> sign_ext_en_out == $past(w1[10] && !unsigned_op_in))
    else $error("sign extension gate wrong");

  c_restore_one: cover property (op_ok && op_code_in == OP_STATUS1_LOAD_INSTR);
  c_frame_pulse: cover property (tx_frame_sync_pin_out);
  c_branch_taken: cover property (branch_take_out);
endmodule

bind csrp_status_pair csrp_status_pair_chk #(.FOUR_MODE(FOUR_MODE)) i_csrp_status_pair_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
  .op_data_in(op_data_in), .unsigned_op_in(unsigned_op_in), .dir_offset_in(dir_offset_in),
  .product_in(product_in), .status_word_zero_out(status_word_zero_out),
  .status_word_one_out(status_word_one_out), .direct_addr_out(direct_addr_out),
  .product_alu_out(product_alu_out), .sign_ext_en_out(sign_ext_en_out), .branch_take_out(branch_take_out),
  .tx_frame_sync_pin_out(tx_frame_sync_pin_out), .tx_frame_sync_pin_oe_out(tx_frame_sync_pin_oe_out));

// file: tb/csrp_status_pair_tb.sv
`timescale 1ns/1ps
module csrp_status_pair_tb;
  import csrp_pkg::*;
  logic clock_in = 1'b0, rst_n_in = 1'b0, op_valid_in = 1'b0, ind_arp_we_in = 1'b0, alu_add_in = 1'b0;
  logic alu_sub_in = 1'b0, alu_high_in = 1'b0, alu_carry_in = 1'b0, shift_c_we_in = 1'b0, shift_c_in = 1'b0;
  logic alu_ovf_in = 1'b0, tc_we_in = 1'b0, tc_in = 1'b0, int_ack_in = 1'b0, unsigned_op_in = 1'b0;
  csrp_op_e op_code_in = OP_NOP;
  logic [15:0] op_data_in = 16'h0000;
  logic [2:0] ind_arp_in = 3'h0;
  logic [6:0] dir_offset_in = 7'h00;
  logic [31:0] product_in = 32'h0000_0000;
  logic [15:0] w0, w1, da, m0, m1;
  logic [31:0] pa;
  logic [82:0] e;
  logic sx, bt, gp, tx, txoe, note = 1'b0, pend = 1'b0;
  logic [1:0] rc;
  logic [82:0] q[$];
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  csrp_status_pair #(.FOUR_MODE(1'b1)) i_csrp_status_pair (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .op_data_in(op_data_in), .ind_arp_we_in(ind_arp_we_in), .ind_arp_in(ind_arp_in), .alu_add_in(alu_add_in),
    .alu_sub_in(alu_sub_in), .alu_high_in(alu_high_in), .alu_carry_in(alu_carry_in),
    .shift_c_we_in(shift_c_we_in), .shift_c_in(shift_c_in), .alu_ovf_in(alu_ovf_in), .tc_we_in(tc_we_in),
    .tc_in(tc_in), .int_ack_in(int_ack_in), .unsigned_op_in(unsigned_op_in), .dir_offset_in(dir_offset_in),
    .product_in(product_in), .status_word_zero_out(w0), .status_word_one_out(w1), .direct_addr_out(da),
    .product_alu_out(pa), .sign_ext_en_out(sx), .branch_take_out(bt), .general_output_pin_out(gp),
    .tx_frame_sync_pin_out(tx), .tx_frame_sync_pin_oe_out(txoe), .ram_cfg_out(rc));

  always #20 clock_in = ~clock_in;

  task automatic complete_run;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One instruction or one event per cycle; the model predicts both words
  task automatic step(input csrp_op_e op, input logic [15:0] d, input logic [3:0] ev, input logic v);
    logic [31:0] pe;
    logic [15:0] de;
    logic se, be, te;
    op_valid_in = (ev == 4'h0);
    op_code_in = op;
    op_data_in = d;
    alu_add_in = (ev == 4'h1) || (ev == 4'h3);
    alu_sub_in = (ev == 4'h2) || (ev == 4'h4);
    alu_high_in = (ev == 4'h3) || (ev == 4'h4);
    alu_carry_in = v;
    shift_c_we_in = (ev == 4'h5);
    shift_c_in = v;
    alu_ovf_in = (ev == 4'h6);
    int_ack_in = (ev == 4'h7);
    tc_we_in = (ev == 4'h8);
    tc_in = v;
    ind_arp_we_in = (ev == 4'h9);
    ind_arp_in = d[2:0];
    unsigned_op_in = 1'($urandom);
    dir_offset_in = 7'($urandom);
    product_in = $urandom;
    note = 1'b1;
    pe = m1[1:0] == PM_LEFT1 ? product_in << 1 : m1[1:0] == PM_LEFT4 ? product_in << 4 :
      m1[1:0] == PM_RIGHT6 ? {{6{product_in[31]}}, product_in[31:6]} : product_in;
    de = {m0[8:0], dir_offset_in};
    se = m1[10] && !unsigned_op_in;
    be = (op == OP_BC && m1[9]) || (op == OP_BNC && !m1[9]);
    be = be || (op == OP_BV && m0[12]) || (op == OP_BNV && !m0[12]);
    be = ev == 4'h0 && (be || (op == OP_BTC && m1[11]) || (op == OP_BNTC && !m1[11]));
    te = ev == 4'h0 && op == OP_TXWR && m1[2];
    case (ev)
      4'h0: case (op)
        OP_LST: m0 = {d[15:11], 1'b1, m0[9], d[8:0]};
        OP_STATUS1_LOAD_INSTR: m1 = d | 16'h0100;
        OP_AUX_POINTER_LOAD_INSTR, OP_MAR: m1[15:13] = m0[15:13];
        OP_LDP, OP_PAGE_LOAD_IMM_INSTR: m0[8:0] = d[8:0];
        OP_SC, OP_RC: m1[9] = (op == OP_SC);
        OP_BLOCK_TO_DATA_INSTR, OP_BLOCK_TO_PROG_INSTR: m1[12] = (op == OP_BLOCK_TO_PROG_INSTR);
        OP_CFG_MODE_LOAD_INSTR: {m1[7], m1[12]} = d[1:0];
        OP_SERIAL_WIDTH_INSTR: m1[3] = d[0];
        OP_INT_DISABLE_INSTR, OP_INT_ENABLE_INSTR: m0[9] = (op == OP_INT_DISABLE_INSTR);
        OP_SATURATE_ON_INSTR, OP_SATURATE_OFF_INSTR: m0[11] = (op == OP_SATURATE_ON_INSTR);
        OP_SPM: m1[1:0] = d[1:0];
        OP_SSXM, OP_RSXM: m1[10] = (op == OP_SSXM);
        OP_STXM, OP_RTXM: m1[2] = (op == OP_STXM);
        OP_SXF, OP_RXF: m1[4] = (op == OP_SXF);
        OP_BV, OP_BNV: m0[12] = 1'b0;
        default: ;
      endcase
      4'h1, 4'h2, 4'h5: m1[9] = v;
      4'h3: m1[9] = m1[9] | v;
      4'h4: m1[9] = m1[9] & v;
      4'h6: m0[12] = 1'b1;
      4'h7: m0[9] = 1'b1;
      4'h8: m1[11] = v;
      4'h9: m1[15:13] = m0[15:13];
      default: ;
    endcase
    if ((ev == 4'h0 && op inside {OP_STATUS1_LOAD_INSTR, OP_AUX_POINTER_LOAD_INSTR, OP_MAR}) || ev == 4'h9) begin
      m0[15:13] = (op == OP_STATUS1_LOAD_INSTR && ev == 4'h0) ? d[15:13] : d[2:0];
    end
    q.push_back({pe, de, se, be, te, m0, m1});
    @(posedge clock_in);
    #1;
  endtask

  task automatic do_reset;
    op_valid_in = 1'b0;
    note = 1'b0;
    rst_n_in = 1'b0;
    repeat (10) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    m0 = 16'h0600;
    m1 = 16'h0770;
  endtask

  always @(posedge clock_in) begin
    pend <= note && rst_n_in;
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end

  always @(negedge clock_in) begin
    if (pend) begin
      e = q.pop_front();
      cmp(w0, e[31:16]);
      cmp(w1, e[15:0]);
      cmp({14'h0, txoe, gp}, {14'h0, e[2], e[4]});
      cmp({14'h0, rc}, {14'h0, e[7], e[12]});
      cmp(da, e[50:35]);
      cmp({13'h0, sx, bt, tx}, {13'h0, e[34:32]});
      cmp(pa[31:16], e[82:67]);
      cmp(pa[15:0], e[66:51]);
    end
  end

  initial begin
    void'($urandom(75932));
    do_reset();
    step(OP_NOP, 16'h0000, 4'h0, 1'b0);
    step(OP_STATUS1_LOAD_INSTR, 16'hffff, 4'h0, 1'b0);
    step(OP_INT_ENABLE_INSTR, 16'h0000, 4'h0, 1'b0);
    step(OP_LST, 16'hffff, 4'h0, 1'b0);
    step(OP_AUX_POINTER_LOAD_INSTR, 16'h0002, 4'h0, 1'b0);
    for (int k = 1; k < 31; k++) step(csrp_op_e'(k), 16'($urandom), 4'h0, 1'b0);
    for (int k = 1; k < 20; k++) step(OP_NOP, 16'($urandom), 4'(k % 10), k[0]);
    step(OP_STXM, 16'h0000, 4'h0, 1'b0);
    step(OP_TXWR, 16'h0000, 4'h0, 1'b0);
    repeat (300) begin
      if ($urandom_range(0, 1) == 0) step(csrp_op_e'($urandom_range(1, 30)), 16'($urandom), 4'h0, 1'b0);
      else step(OP_NOP, 16'($urandom), 4'($urandom_range(1, 9)), 1'($urandom));
    end
    do_reset();
    step(OP_NOP, 16'h0000, 4'h0, 1'b0);
    step(OP_BV, 16'h0000, 4'h0, 1'b0);
    note = 1'b0;
    repeat (3) @(posedge clock_in);
    complete_run();
  end
endmodule
